// file: common/sysclk_params.svh
// register offsets, field positions, reset values and timing counts for the clock source block
`ifndef SYSCLK_PARAMS_SVH
`define SYSCLK_PARAMS_SVH
`define SYSCLK_OFS_TRIM 4'h0
`define SYSCLK_OFS_DIV 4'h4
`define SYSCLK_OFS_SRC 4'h8
`define SYSCLK_OFS_STAT 4'hC
`define SYSCLK_TRIM_MSB 6
`define SYSCLK_UNLOCK_BIT 7
`define SYSCLK_SEL_MSB 3
`define SYSCLK_SEL_RST_DIV1 4'h0
`define SYSCLK_SEL_RST_DIV8 4'h3
`define SYSCLK_SEL_MAX 4'h8
`define SYSCLK_UNLOCK_CYCLES 3'h4
`define SYSCLK_PD_START_CK 16'h0006
`define SYSCLK_RST_START_CK 16'h000E
`define SYSCLK_LONG_WAIT_4MS 4
`define SYSCLK_LONG_WAIT_64MS 64
`define SYSCLK_CLK_MHZ 100
`define SYSCLK_MS_CYCLES(ms) ((ms) * 1000 * `SYSCLK_CLK_MHZ)
`define SYSCLK_RESP_OKAY 2'h0
`define SYSCLK_RESP_SLVERR 2'h2
`endif

// file: common/sysclk_pkg.sv
// types for the clock source and divider block
package sysclk_pkg;
    typedef enum logic [1:0] {SRC_EXT, SRC_RC48, SRC_RC96, SRC_LP128} sysclk_src_e;
    typedef enum logic [1:0] {ST_RESET_WAIT, ST_LONG_WAIT, ST_RUN, ST_WAKE_WAIT} sysclk_state_e;
    typedef struct packed {
        logic [1:0] source_select_fuse;
        logic [1:0] startup_time_fuse;
        logic initial_div8_fuse;
        logic [6:0] trim_factory;
    } sysclk_fuse_s;
    typedef struct packed {
        logic rc48_en;
        logic rc96_en;
        logic lp128_en;
        logic ext_en;
    } sysclk_osc_en_s;
endpackage

// file: hdl/sysclk_ctrl.sv
// clock source selection, start-up delay, trim register and glitch-free power-of-two divider
`timescale 1ns/10ps
`include "sysclk_params.svh"

// Overview of operation
// - trim register bit 7 reads zero
// - trim value loaded from factory at reset
// - larger trim value raises oscillator frequency
// - fuse 00 selects external clock input
// - fuse 11 selects low-power 128 kHz oscillator
// - reset start-up delay from startup fuse; wake-up delay fixed at 6 source clocks
// - divided clock feeds all clock domains
// - unlock set only with other bits zero
// - unlock clears after four cycles or select write
// - unlock rewrite neither restarts nor clears
// - select written only during open unlock window
// - select resets to 0000 or 0011 by fuse
// - codes 0..8 divide 1..256, others reserved
// - any select value writable regardless of fuse
// - divider register bits 6..4 read zero
// - divider switches without glitch or overshoot
// - fuse 10 is 9.6 MHz, 01 is 4.8 MHz
module sysclk_ctrl
(
    input wire logic sys_clk_i,                      // 100 MHz system clock
    input wire logic reset_n_i,                      // synchronous reset, active low
    input wire sysclk_pkg::sysclk_fuse_s fuse_i,     // static fuse values
    input wire logic power_down_i,                   // sleep controller stops the source
    input wire logic ext_clock_in_i,                 // external clock pin
    input wire logic rc_clk_i,                       // calibrated rc oscillator output
    input wire logic lp128_clk_i,                    // low-power oscillator output
    input wire logic [3:0] s_axi_awaddr,             // write address
    input wire logic s_axi_awvalid,                  // write address valid
    output logic s_axi_awready,                      // write address ready
    input wire logic [31:0] s_axi_wdata,             // write data
    input wire logic [3:0] s_axi_wstrb,              // write strobes
    input wire logic s_axi_wvalid,                   // write data valid
    output logic s_axi_wready,                       // write data ready
    output logic [1:0] s_axi_bresp,                  // write response
    output logic s_axi_bvalid,                       // write response valid
    input wire logic s_axi_bready,                   // write response ready
    input wire logic [3:0] s_axi_araddr,             // read address
    input wire logic s_axi_arvalid,                  // read address valid
    output logic s_axi_arready,                      // read address ready
    output logic [31:0] s_axi_rdata,                 // read data
    output logic [1:0] s_axi_rresp,                  // read response
    output logic s_axi_rvalid,                       // read data valid
    input wire logic s_axi_rready,                   // read data ready
    output logic [6:0] trim_value_o,                 // trim to rc oscillator
    output logic rc_fast_o,                          // rc oscillator runs at 9.6 MHz
    output sysclk_pkg::sysclk_osc_en_s osc_en_o,     // oscillator enables
    output logic [8:0] div_tick_o,                   // one-hot divider factor
    output logic clk_gate_en_o,                      // system clock running
    output logic core_clk_en_o                       // divided enable for core, io, adc, flash
);
    localparam int MS4_CYC = `SYSCLK_MS_CYCLES(`SYSCLK_LONG_WAIT_4MS);
    localparam int MS64_CYC = `SYSCLK_MS_CYCLES(`SYSCLK_LONG_WAIT_64MS);

    sysclk_pkg::sysclk_fuse_s fuse_q;
    sysclk_pkg::sysclk_src_e src_q;
    sysclk_pkg::sysclk_state_e state_q;
    logic [2:0] sync_ext_q, sync_rc_q, sync_lp_q;
    logic src_edge;
    logic [15:0] ck_cnt_q;
    logic [23:0] ms_cnt_q;
    logic [6:0] trim_q;
    logic unlock_q;
    logic [2:0] unlock_cnt_q;
    logic [3:0] sel_q;
    logic [3:0] sel_act_q;
    logic [7:0] ripple_q;
    logic tick;
    logic reset_seen_q;
    logic aw_q, w_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go, wr_trim, wr_div;
    logic [31:0] rd_mux;

    // fuses captured at reset only; changes after release are ignored
    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
            fuse_q <= fuse_i;
    end

    // follows the pins while reset is low, so the enables are right at the first running edge
    always_ff @(posedge sys_clk_i)
    begin
        unique case (reset_n_i ? fuse_q.source_select_fuse : fuse_i.source_select_fuse)
            2'h0: src_q <= sysclk_pkg::SRC_EXT;
            2'h1: src_q <= sysclk_pkg::SRC_RC48;
            2'h2: src_q <= sysclk_pkg::SRC_RC96;
            2'h3: src_q <= sysclk_pkg::SRC_LP128;
        endcase
    end

    assign rc_fast_o = (src_q == sysclk_pkg::SRC_RC96);
    assign osc_en_o.rc48_en = (src_q == sysclk_pkg::SRC_RC48) && !power_down_i;
    assign osc_en_o.rc96_en = (src_q == sysclk_pkg::SRC_RC96) && !power_down_i;
    assign osc_en_o.lp128_en = (src_q == sysclk_pkg::SRC_LP128) && !power_down_i;
    assign osc_en_o.ext_en = (src_q == sysclk_pkg::SRC_EXT) && !power_down_i;

    // source clocks are foreign; two flops, then the third stage is the edge reference
    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            sync_ext_q <= 3'h0;
            sync_rc_q <= 3'h0;
            sync_lp_q <= 3'h0;
        end
        else
        begin
            sync_ext_q <= {sync_ext_q[1:0], ext_clock_in_i};
            sync_rc_q <= {sync_rc_q[1:0], rc_clk_i};
            sync_lp_q <= {sync_lp_q[1:0], lp128_clk_i};
        end
    end

    always_comb
    begin
        unique case (src_q)
            sysclk_pkg::SRC_EXT: src_edge = sync_ext_q[1] && !sync_ext_q[2];
            sysclk_pkg::SRC_LP128: src_edge = sync_lp_q[1] && !sync_lp_q[2];
            default: src_edge = sync_rc_q[1] && !sync_rc_q[2];
        endcase
    end

    // start-up: counted source clocks, then the real-time part in system cycles
    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= sysclk_pkg::ST_RESET_WAIT;
            ck_cnt_q <= 16'h0000;
            ms_cnt_q <= 24'h000000;
            reset_seen_q <= 1'b0;
        end
        else
            unique case (state_q)
                sysclk_pkg::ST_RESET_WAIT:
                begin
                    if (src_edge)
                        ck_cnt_q <= ck_cnt_q + 16'h0001;
                    if (src_edge && ck_cnt_q == `SYSCLK_RST_START_CK - 16'h0001)
                    begin
                        ck_cnt_q <= 16'h0000;
                        unique case (fuse_q.startup_time_fuse)
                            2'h1:
                            begin
                                ms_cnt_q <= 24'(MS4_CYC - 1);
                                state_q <= sysclk_pkg::ST_LONG_WAIT;
                            end
                            2'h2:
                            begin
                                ms_cnt_q <= 24'(MS64_CYC - 1);
                                state_q <= sysclk_pkg::ST_LONG_WAIT;
                            end
                            default: state_q <= sysclk_pkg::ST_RUN; // reserved 11 treated as 00
                        endcase
                    end
                end
                sysclk_pkg::ST_LONG_WAIT:
                begin
                    ms_cnt_q <= ms_cnt_q - 24'h000001;
                    if (ms_cnt_q == 24'h000000)
                        state_q <= sysclk_pkg::ST_RUN;
                end
                sysclk_pkg::ST_RUN:
                begin
                    reset_seen_q <= 1'b1;
                    if (power_down_i)
                        state_q <= sysclk_pkg::ST_WAKE_WAIT;
                end
                sysclk_pkg::ST_WAKE_WAIT:
                begin
                    if (!power_down_i && src_edge)
                        ck_cnt_q <= ck_cnt_q + 16'h0001;
                    if (!power_down_i && src_edge && ck_cnt_q == `SYSCLK_PD_START_CK - 16'h0001)
                    begin
                        ck_cnt_q <= 16'h0000;
                        state_q <= sysclk_pkg::ST_RUN;
                    end
                end
            endcase
    end

    assign clk_gate_en_o = (state_q == sysclk_pkg::ST_RUN);

    // axi4-lite write: address and data captured independently
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready = !w_q && !s_axi_bvalid;
    assign wr_go = aw_q && w_q && !s_axi_bvalid;

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SYSCLK_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q == `SYSCLK_OFS_TRIM || awaddr_q == `SYSCLK_OFS_DIV ||
                                awaddr_q == `SYSCLK_OFS_SRC || awaddr_q == `SYSCLK_OFS_STAT)
                               ? `SYSCLK_RESP_OKAY : `SYSCLK_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // registers are one byte wide; only lane 0 writes them
    assign wr_trim = wr_go && awaddr_q == `SYSCLK_OFS_TRIM && wstrb_q[0];
    assign wr_div = wr_go && awaddr_q == `SYSCLK_OFS_DIV && wstrb_q[0];

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
            trim_q <= 7'h00;
        else if (!reset_seen_q && state_q == sysclk_pkg::ST_RESET_WAIT)
            trim_q <= fuse_q.trim_factory;
        else if (wr_trim)
            trim_q <= wdata_q[`SYSCLK_TRIM_MSB:0];
    end

    assign trim_value_o = trim_q; // step size and ceiling are software's duty

    // unlock window: set by a clean unlock write, held for four cycles
    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            unlock_q <= 1'b0;
            unlock_cnt_q <= 3'h0;
        end
        else if (wr_div && !wdata_q[`SYSCLK_UNLOCK_BIT] && unlock_q)
        begin
            unlock_q <= 1'b0;
            unlock_cnt_q <= 3'h0;
        end
        else if (unlock_q)
        begin
            unlock_cnt_q <= unlock_cnt_q + 3'h1;
            if (unlock_cnt_q == `SYSCLK_UNLOCK_CYCLES - 3'h1)
                unlock_q <= 1'b0;
        end
        else if (wr_div && wdata_q[7:0] == 8'h80)
        begin
            unlock_q <= 1'b1;
            unlock_cnt_q <= 3'h0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
            sel_q <= `SYSCLK_SEL_RST_DIV1;
        else if (!reset_seen_q && state_q == sysclk_pkg::ST_RESET_WAIT)
            sel_q <= fuse_q.initial_div8_fuse ? `SYSCLK_SEL_RST_DIV1 : `SYSCLK_SEL_RST_DIV8;
        else if (wr_div && unlock_q && !wdata_q[`SYSCLK_UNLOCK_BIT])
            sel_q <= wdata_q[`SYSCLK_SEL_MSB:0];
    end

    // free-running ripple count; new setting taken only when old and new periods both end,
    // so no output pulse comes sooner than either setting would give
    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
            ripple_q <= 8'h00;
        else if (src_edge)
            ripple_q <= ripple_q + 8'h01;
    end

    function automatic logic period_end(input logic [3:0] s, input logic [7:0] r);
        logic [7:0] m;
        m = (s >= `SYSCLK_SEL_MAX) ? 8'hFF : 8'((9'h001 << s) - 9'h001);
        period_end = ((r & m) == m);
    endfunction

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
            sel_act_q <= `SYSCLK_SEL_RST_DIV1;
        else if (src_edge && period_end(sel_act_q, ripple_q) && period_end(sel_q, ripple_q))
            sel_act_q <= (sel_q > `SYSCLK_SEL_MAX) ? `SYSCLK_SEL_MAX : sel_q;
    end

    assign tick = src_edge && period_end(sel_act_q, ripple_q);

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
            core_clk_en_o <= 1'b0;
        else
            core_clk_en_o <= tick && clk_gate_en_o && !power_down_i;
    end

    assign div_tick_o = 9'(9'h001 << sel_act_q);

    // axi4-lite read
    always_comb
    begin
        unique case (s_axi_araddr)
            `SYSCLK_OFS_TRIM: rd_mux = {25'h0000000, trim_q};
            `SYSCLK_OFS_DIV: rd_mux = {24'h000000, unlock_q, 3'h0, sel_q};
            `SYSCLK_OFS_SRC: rd_mux = {27'h0000000, fuse_q.initial_div8_fuse, fuse_q.startup_time_fuse,
                                       fuse_q.source_select_fuse};
            `SYSCLK_OFS_STAT: rd_mux = {29'h00000000, rc_fast_o, state_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SYSCLK_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= (s_axi_araddr == `SYSCLK_OFS_TRIM || s_axi_araddr == `SYSCLK_OFS_DIV ||
                            s_axi_araddr == `SYSCLK_OFS_SRC || s_axi_araddr == `SYSCLK_OFS_STAT)
                           ? `SYSCLK_RESP_OKAY : `SYSCLK_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule

// file: sim/sysclk_ctrl_chk.sv
// concurrent checks on the ports of the clock source and divider block
`timescale 1ns/10ps
`include "sysclk_params.svh"
module sysclk_ctrl_chk
(
    input wire logic sys_clk_i,                   // clock
    input wire logic reset_n_i,                   // reset
    input wire sysclk_pkg::sysclk_fuse_s fuse_i,  // fuses
    input wire logic power_down_i,                // source stop
    input wire logic [3:0] s_axi_araddr,          // read address
    input wire logic s_axi_arvalid,               // read valid
    input wire logic s_axi_arready,               // read ready
    input wire logic [31:0] s_axi_rdata,          // read data
    input wire logic [6:0] trim_value_o,          // trim
    input wire logic rc_fast_o,                   // fast rc
    input wire sysclk_pkg::sysclk_osc_en_s osc_en_o, // enables
    input wire logic [8:0] div_tick_o,            // divide code
    input wire logic clk_gate_en_o,               // running
    input wire logic core_clk_en_o                // divided enable
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_rd(logic [3:0] a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence

    a_trim_msb_zero: assert property (s_rd(`SYSCLK_OFS_TRIM)
        |=> s_axi_rdata == {25'h0, trim_value_o})
        else $error("trim read has upper bits set or differs from trim output");
    a_div_resv_zero: assert property (s_rd(`SYSCLK_OFS_DIV)
        |=> s_axi_rdata[31:8] == 0 && s_axi_rdata[6:4] == 0)
        else $error("divider read has reserved bits set");
    a_src_fuse_readback: assert property (s_rd(`SYSCLK_OFS_SRC)
        |=> s_axi_rdata == {27'h0, fuse_i.initial_div8_fuse, fuse_i.startup_time_fuse, fuse_i.source_select_fuse})
        else $error("fuse readback differs from fuses");
    a_ext_source_sel: assert property (!power_down_i && fuse_i.source_select_fuse == 2'b00
        |-> osc_en_o == 4'b0001)
        else $error("external source not selected");
    a_lp_source_sel: assert property (!power_down_i && fuse_i.source_select_fuse == 2'b11
        |-> osc_en_o == 4'b0010)
        else $error("low-power source not selected");
    a_rc_fast_sel: assert property (!power_down_i && fuse_i.source_select_fuse == 2'b10
        |-> osc_en_o == 4'b0100 && rc_fast_o)
        else $error("fast rc source not selected");
    a_rc_slow_sel: assert property (!power_down_i && fuse_i.source_select_fuse == 2'b01
        |-> osc_en_o == 4'b1000 && !rc_fast_o)
        else $error("slow rc source not selected");
    a_tick_one_hot: assert property ($onehot(div_tick_o))
        else $error("divide code not one-hot");
    a_core_en_gated: assert property (core_clk_en_o |-> clk_gate_en_o)
        else $error("divided enable outside run");
    a_pd_osc_off: assert property (power_down_i |-> osc_en_o == 4'b0000)
        else $error("oscillator enabled in power-down");
    a_pd_wake_wait: assert property ($fell(power_down_i) |=> !clk_gate_en_o [*2])
        else $error("clock released without wake wait");
endmodule

bind sysclk_ctrl sysclk_ctrl_chk sysclk_ctrl_chk_inst (.sys_clk_i, .reset_n_i, .fuse_i, .power_down_i,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .trim_value_o, .rc_fast_o, .osc_en_o,
    .div_tick_o, .clk_gate_en_o, .core_clk_en_o);

// file: sim/test_sysclk_ctrl.sv
// self-checking bench for the clock source and divider block
`timescale 1ns/10ps
`include "sysclk_params.svh"
module test_sysclk_ctrl;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    sysclk_pkg::sysclk_fuse_s fuse_i = '0;
    logic power_down_i = 1'b0;
    logic ext_clock_in_i = 1'b0;
    logic rc_clk_i = 1'b0;
    logic lp128_clk_i = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b1;
    logic [3:0] s_axi_araddr = 4'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rdv;
    logic [6:0] trim_value_o;
    logic rc_fast_o, clk_gate_en_o, core_clk_en_o;
    sysclk_pkg::sysclk_osc_en_s osc_en_o;
    logic [8:0] div_tick_o;
    logic [1:0] rsp;
    logic [3:0] src_cnt = 4'h0;
    logic [3:0] en_tab [4] = '{4'b0001, 4'b1000, 4'b0100, 4'b0010};
    int fails = 0;
    int checked = 0;
    int n, cnt;

    sysclk_ctrl sysclk_ctrl_inst (.sys_clk_i, .reset_n_i, .fuse_i, .power_down_i, .ext_clock_in_i, .rc_clk_i,
        .lp128_clk_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trim_value_o, .rc_fast_o, .osc_en_o,
        .div_tick_o, .clk_gate_en_o, .core_clk_en_o);

    always #5 sys_clk_i = ~sys_clk_i;

    // source clocks: external period 4, rc period 2, low-power period 16 system cycles
    // fixed periods, so the external clock never jumps between cycles
    always @(posedge sys_clk_i)
    begin
        src_cnt <= src_cnt + 4'h1;
        ext_clock_in_i <= src_cnt[1];
        rc_clk_i <= src_cnt[0];
        lp128_clk_i <= src_cnt[3];
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tmo(input string nm);
        fails++;
        $display("CHECK FAILED %s expected done seen timeout", nm);
        final_report();
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int e, input int g);
        checked++;
        if (g < e - 1 || g > e + 1)
        begin
            fails++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // address and data offered together; each dropped at the edge where its own ready is seen
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_pend, w_pend;
        aw_pend = 1'b1;
        w_pend = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50 && (aw_pend || w_pend); n++)
        begin
            @(posedge sys_clk_i);
            if (aw_pend && s_axi_awready === 1'b1)
            begin
                aw_pend = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_pend && s_axi_wready === 1'b1)
            begin
                w_pend = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        @(posedge sys_clk_i);
        for (n = n; n < 100 && s_axi_bvalid !== 1'b1; n++) @(posedge sys_clk_i);
        if (n >= 100)
            tmo("write");
        rsp = s_axi_bresp;
    endtask

    task automatic rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(posedge sys_clk_i);
        for (n = 0; n < 50 && s_axi_arready !== 1'b1; n++) @(posedge sys_clk_i);
        s_axi_arvalid <= 1'b0;
        @(posedge sys_clk_i);
        for (n = n; n < 100 && s_axi_rvalid !== 1'b1; n++) @(posedge sys_clk_i);
        if (n >= 100)
            tmo("read");
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        rd(a);
        chk("register read", e, rdv);
    endtask

    task automatic set_div(input logic [3:0] c);
        wr(`SYSCLK_OFS_DIV, 32'h80, 4'hF);
        wr(`SYSCLK_OFS_DIV, {28'h0, c}, 4'hF);
    endtask

    task automatic reset_dut(input logic [1:0] src, input logic div8);
        int k;
        reset_n_i <= 1'b0;
        fuse_i <= {src, 2'b00, div8, 7'h5A};
        repeat (4) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        rdv = 32'h0;
        for (k = 0; k < 300 && rdv[1:0] !== 2'h2; k++) rd(`SYSCLK_OFS_STAT);
        if (k >= 300)
            tmo("start-up");
    endtask

    initial
    begin
        reset_dut(2'b00, 1'b0);
        rchk(`SYSCLK_OFS_TRIM, 32'h5A);
        rchk(`SYSCLK_OFS_DIV, 32'h03);
        rchk(`SYSCLK_OFS_SRC, 32'h00);
        // small trim steps only, and no memory write runs meanwhile
        wr(`SYSCLK_OFS_TRIM, 32'hE0, 4'hF);
        rchk(`SYSCLK_OFS_TRIM, 32'h60);
        chk("trim output", 32'h60, {25'h0, trim_value_o});
        wr(`SYSCLK_OFS_TRIM, 32'h52, 4'h0);
        rchk(`SYSCLK_OFS_TRIM, 32'h60);
        wr(`SYSCLK_OFS_DIV, 32'h05, 4'hF);
        rchk(`SYSCLK_OFS_DIV, 32'h03);
        wr(`SYSCLK_OFS_DIV, 32'h81, 4'hF);
        wr(`SYSCLK_OFS_DIV, 32'h05, 4'hF);
        rchk(`SYSCLK_OFS_DIV, 32'h03);
        wr(`SYSCLK_OFS_DIV, 32'h80, 4'hF);
        repeat (8) @(posedge sys_clk_i);
        wr(`SYSCLK_OFS_DIV, 32'h05, 4'hF);
        rchk(`SYSCLK_OFS_DIV, 32'h03);
        // a restarted window would still be open for the third write
        wr(`SYSCLK_OFS_DIV, 32'h80, 4'hF);
        set_div(4'h5);
        rchk(`SYSCLK_OFS_DIV, 32'h03);
        for (int c = 0; c <= 8; c++)
        begin
            set_div(c[3:0]);
            rchk(`SYSCLK_OFS_DIV, c);
            for (n = 0; n < 4000 && div_tick_o !== (9'h001 << c); n++) @(posedge sys_clk_i);
            if (n >= 4000)
                tmo("divide switch");
            cnt = 0;
            repeat (512)
            begin
                @(posedge sys_clk_i);
                if (core_clk_en_o === 1'b1)
                    cnt++;
            end
            chk_rng("divided pulses", 128 >> c, cnt);
        end
        // reserved code reads back as written but divides as the largest factor
        set_div(4'hC);
        rchk(`SYSCLK_OFS_DIV, 32'h0C);
        repeat (1100) @(posedge sys_clk_i);
        chk("reserved code", 32'h100, {23'h0, div_tick_o});
        rd(4'h2);
        chk("unmapped read data", 32'h0, rdv);
        chk("unmapped read resp", {30'h0, `SYSCLK_RESP_SLVERR}, {30'h0, rsp});
        wr(4'h2, 32'h1, 4'hF);
        chk("unmapped write", `SYSCLK_RESP_SLVERR, rsp);
        power_down_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        chk("sources off", 32'h0, {28'h0, osc_en_o});
        power_down_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        chk("wake wait", 32'h0, {31'h0, clk_gate_en_o});
        for (n = 0; n < 500 && clk_gate_en_o !== 1'b1; n++) @(posedge sys_clk_i);
        if (n >= 500)
            tmo("wake");
        for (int s = 1; s < 4; s++)
        begin
            reset_dut(s[1:0], 1'b1);
            chk("source enables", {28'h0, en_tab[s]}, {28'h0, osc_en_o});
            chk("fast rc", {31'h0, s == 2}, {31'h0, rc_fast_o});
            rchk(`SYSCLK_OFS_DIV, 32'h00);
            rchk(`SYSCLK_OFS_SRC, 32'h10 | s);
        end
        final_report();
    end
endmodule
